/* File: core/dms_core.sv */
// Distance range decision and estimation on the defect-corrected pixel stream.
// Assumes upstream marks frame start/end and supplies zone and calibration
// weights with each pixel; configuration words are already assembled.
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// RULE1 - Input stream is already defect corrected
// RULE2 - Four ranges split at 30, 50, 120 cm
// RULE3 - Colour from 30 cm, monochrome below
// RULE4 - Estimate from per-channel gradient sharpness comparison
// RULE5 - Blue votes macro, green portrait, red landscape
// RULE6 - Calibration weights scale channel sharpness first
// RULE7 - Region selection chooses spatial vote weights
// RULE8 - Super macro outputs blue-based monochrome image
// RULE9 - Host uses two-wire bus, 16-bit index
// RULE10 - All control settings host readable and writable
// RULE11 - Mode 0 off, 1 apply, 2 estimate
// RULE12 - Focus below 0x8000 manual, else automatic
// RULE13 - Host estimates one frame before applying
// RULE14 - Region codes: uniform, centre, large, narrow
// RULE15 - Manual distance uses same range boundaries
// RULE16 - Settings sampled only at frame start
module dms_core
    import dms_pkg::*;
#(
    parameter int DW = 10,                      // Bits per colour sample
    parameter int CW = 8,                       // Calibration weight bits
    parameter int AW = 32                       // Vote accumulator bits
) (
    input  wire logic          sys_clk,
    input  wire logic          rst_b,
    input  wire logic [1:0]    cfg_mode,
    input  wire logic [15:0]   cfg_focus,
    input  wire logic [3:0]    cfg_roi,
    input  wire logic          in_valid,
    output logic               in_ready,
    input  wire logic          in_sof,
    input  wire logic          in_eof,
    input  wire logic [DW-1:0] in_r,
    input  wire logic [DW-1:0] in_g,
    input  wire logic [DW-1:0] in_b,
    input  wire logic [2:0]    in_zone_x,
    input  wire logic [2:0]    in_zone_y,
    input  wire logic [CW-1:0] cal_w_r,
    input  wire logic [CW-1:0] cal_w_g,
    input  wire logic [CW-1:0] cal_w_b,
    output logic               out_valid,
    input  wire logic          out_ready,
    output logic               out_sof,
    output logic               out_eof,
    output logic [DW-1:0]      out_r,
    output logic [DW-1:0]      out_g,
    output logic [DW-1:0]      out_b,
    output logic [1:0]         out_range,
    output logic               out_corr,
    output logic [7:0]         est_dist,
    output logic               est_valid,
    output logic [1:0]         act_mode_rd,
    output logic [15:0]        act_focus_rd,
    output logic [3:0]         act_roi_rd
);
    localparam int WW = 3 * DW + 5;             // Buffer word width
    localparam int PW = DW + CW;                // Weighted sharpness width
    // ---------------------------------------------------------------
    // Frame configuration
    // ---------------------------------------------------------------
    logic [1:0]  cfg_mode_q;                    // Mode held for the frame
    logic [15:0] cfg_focus_q;                   // Focus held for the frame
    logic [3:0]  cfg_roi_q;                     // Region code held for the frame
    logic [1:0]  next_cfg_mode;
    logic [15:0] next_cfg_focus;
    logic [3:0]  next_cfg_roi;
    logic        acc;                           // Pixel taken this cycle
    dms_mode_e   act_mode;                      // Mode seen by this pixel
    logic [15:0] act_focus;
    logic [3:0]  act_roi;
    assign acc = in_valid && in_ready;
    // Live settings only enter at a frame start, so one frame never mixes two
    always_comb begin
        next_cfg_mode  = cfg_mode_q;
        next_cfg_focus = cfg_focus_q;
        next_cfg_roi   = cfg_roi_q;
        if (acc && in_sof) begin
            next_cfg_mode  = cfg_mode;          // RULE16
            next_cfg_focus = cfg_focus;
            next_cfg_roi   = cfg_roi;
        end
        act_mode  = dms_mode_e'(in_sof ? cfg_mode : cfg_mode_q);
        act_focus = in_sof ? cfg_focus : cfg_focus_q;
        act_roi   = in_sof ? cfg_roi : cfg_roi_q;
    end
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            cfg_mode_q  <= DMS_MODE_OFF;
            cfg_focus_q <= FOCUS_AUTO_BIT;
            cfg_roi_q   <= 4'h0;
        end else begin
            cfg_mode_q  <= next_cfg_mode;
            cfg_focus_q <= next_cfg_focus;
            cfg_roi_q   <= next_cfg_roi;
        end
    end
    // Settings in force, read back by the host side of the control bus
    assign act_mode_rd  = cfg_mode_q;           // RULE10
    assign act_focus_rd = cfg_focus_q;          // RULE9
    assign act_roi_rd   = cfg_roi_q;
    // ---------------------------------------------------------------
    // Sharpness voting
    // ---------------------------------------------------------------
    logic [DW-1:0] prev_r, prev_g, prev_b;      // Previous taken pixel of the frame
    logic [DW-1:0] next_prev_r, next_prev_g, next_prev_b;
    logic [DW-1:0] grad_r, grad_g, grad_b;      // Horizontal gradients
    logic [PW-1:0] wt_r, wt_g, wt_b;            // Calibrated sharpness
    logic [2:0]    roi_w;                       // Spatial weight of this zone
    logic          edge_x, edge_y, mid_x, mid_y;
    logic [AW-1:0] votes [3];                   // 0 macro, 1 portrait, 2 landscape
    logic [AW-1:0] next_votes [3];
    logic [1:0]    win;                         // Winning vote slot
    logic          has_vote;
    logic [7:0]    next_est_dist;
    logic          next_est_valid;
    logic          estimating;
    function automatic logic [DW-1:0] absdiff(input logic [DW-1:0] a, input logic [DW-1:0] b);
        return (a > b) ? a - b : b - a;
    endfunction
    always_comb begin
        next_prev_r = acc ? in_r : prev_r;
        next_prev_g = acc ? in_g : prev_g;
        next_prev_b = acc ? in_b : prev_b;
        // No gradient on the first pixel of a frame: nothing to compare with
        grad_r = in_sof ? '0 : absdiff(in_r, prev_r);         // RULE4
        grad_g = in_sof ? '0 : absdiff(in_g, prev_g);
        grad_b = in_sof ? '0 : absdiff(in_b, prev_b);
        // Field curvature correction before any comparison
        wt_r = PW'(grad_r) * PW'(cal_w_r);                    // RULE6
        wt_g = PW'(grad_g) * PW'(cal_w_g);
        wt_b = PW'(grad_b) * PW'(cal_w_b);
        // Blue wins ties, then green: nearer range preferred in overlaps
        has_vote = (wt_r != '0) || (wt_g != '0) || (wt_b != '0);
        if (wt_b >= wt_g && wt_b >= wt_r)
            win = 2'h0;                                       // RULE5
        else if (wt_g >= wt_r)
            win = 2'h1;
        else
            win = 2'h2;
        // Zone weights over the 5x5 grid
        mid_x  = (in_zone_x == ZONE_MID);
        mid_y  = (in_zone_y == ZONE_MID);
        edge_x = (in_zone_x < ZONE_LO) || (in_zone_x > ZONE_HI);
        edge_y = (in_zone_y < ZONE_LO) || (in_zone_y > ZONE_HI);
        unique case (act_roi)                                 // RULE14
            ROI_CENTRE: roi_w = (mid_x && mid_y) ? ROI_W_HIGH :
                                (!edge_x && !edge_y) ? ROI_W_MID : ROI_W_ONE;
            ROI_LARGE:  roi_w = (!edge_x && !edge_y) ? ROI_W_ONE : ROI_W_NONE;
            ROI_NARROW: roi_w = (mid_x && mid_y) ? ROI_W_ONE : ROI_W_NONE;
            default:    roi_w = ROI_W_ONE;     // 0, 1 and unused codes: uniform
        endcase
        estimating = acc && (act_mode == DMS_MODE_ESTIM);    // RULE11
        for (int i = 0; i < 3; i++) begin
            next_votes[i] = votes[i];
            if (estimating && has_vote && win == 2'(i))
                next_votes[i] = votes[i] + AW'(roi_w);        // RULE7
        end
        // Frame end closes the count and publishes the winner
        next_est_dist  = est_dist;
        next_est_valid = est_valid;
        if (estimating && in_eof) begin
            if (next_votes[0] >= next_votes[1] && next_votes[0] >= next_votes[2])
                next_est_dist = EST_MACRO_CM;
            else if (next_votes[1] >= next_votes[2])
                next_est_dist = EST_PORTRAIT_CM;
            else
                next_est_dist = EST_LANDSCAPE_CM;
            next_est_valid = 1'b1;
            for (int i = 0; i < 3; i++)
                next_votes[i] = '0;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            prev_r    <= '0;
            prev_g    <= '0;
            prev_b    <= '0;
            est_dist  <= EST_DIST_RST;
            est_valid <= 1'b0;
            votes     <= '{default: '0};
        end else begin
            prev_r    <= next_prev_r;
            prev_g    <= next_prev_g;
            prev_b    <= next_prev_b;
            est_dist  <= next_est_dist;
            est_valid <= next_est_valid;
            votes     <= next_votes;
        end
    end
    // ---------------------------------------------------------------
    // Correction decision per pixel
    // ---------------------------------------------------------------
    dms_range_e    word_range;
    logic          word_corr;
    logic [DW-1:0] word_r, word_g;
    logic [WW-1:0] word;
    always_comb begin
        word_corr = 1'b0;
        if (act_focus < FOCUS_AUTO_BIT) begin
            word_range = dms_classify(act_focus);                       // RULE12 RULE15 RULE2
            word_corr  = (act_mode == DMS_MODE_APPLY);
        end else begin
            // Auto cannot reach super macro: the estimate never reports it
            word_range = dms_classify({8'h00, est_dist});
            word_corr  = (act_mode == DMS_MODE_APPLY) && est_valid;     // RULE13
        end
        // Below 30 cm only blue carries detail: all channels follow it
        if (word_corr && word_range == DMS_RANGE_SMACRO) begin
            word_r = in_b;                                              // RULE8 RULE3
            word_g = in_b;
        end else begin
            word_r = in_r;
            word_g = in_g;
        end
        // Pixels come straight from defect correction, never reordered
        word = {in_sof, in_eof, word_corr, word_range, word_r, word_g, in_b};  // RULE1
    end
    // ---------------------------------------------------------------
    // Two-entry output buffer
    // ---------------------------------------------------------------
    logic [WW-1:0] buf_mem [2];                 // Storage slots
    logic [WW-1:0] next_buf_mem [2];
    logic          wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic [1:0]    count, next_count;
    logic          pop;
    // Full buffer back-pressures the pixel source, so no word is lost
    assign in_ready  = (count != BUF_FULL);
    assign out_valid = (count != 2'h0);
    assign pop       = out_valid && out_ready;
    assign {out_sof, out_eof, out_corr, out_range, out_r, out_g, out_b} = buf_mem[rd_ptr];
    always_comb begin
        next_buf_mem = buf_mem;
        next_wr_ptr  = wr_ptr;
        next_rd_ptr  = rd_ptr;
        if (acc) begin
            next_buf_mem[wr_ptr] = word;
            next_wr_ptr          = ~wr_ptr;
        end
        if (pop)
            next_rd_ptr = ~rd_ptr;
        next_count = count + 2'(acc) - 2'(pop);
    end
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            buf_mem    <= '{default: '0};
            wr_ptr     <= 1'b0;
            rd_ptr     <= 1'b0;
            count      <= 2'h0;
        end else begin
            buf_mem <= next_buf_mem;
            wr_ptr  <= next_wr_ptr;
            rd_ptr  <= next_rd_ptr;
            count   <= next_count;
        end
    end
    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    a_mono_blue_out: assert property (@(posedge sys_clk) disable iff (!rst_b)   // RULE8
        out_valid && out_corr && out_range == DMS_RANGE_SMACRO |-> out_r == out_b && out_g == out_b)
        else $error("super macro output not blue monochrome");
    a_range_bounds: assert property (@(posedge sys_clk) disable iff (!rst_b)    // RULE2
        acc && act_focus < FOCUS_AUTO_BIT |=> buf_mem[$past(wr_ptr)][DW*3+1:DW*3] == (($past(act_focus) < 16'h001E) ?
        2'h0 : ($past(act_focus) < 16'h0032) ? 2'h1 : ($past(act_focus) < 16'h0078) ? 2'h2 : 2'h3))
        else $error("manual distance mapped to wrong range");
    a_no_corr_idle: assert property (@(posedge sys_clk) disable iff (!rst_b)    // RULE11
        acc && act_mode != DMS_MODE_APPLY |=> !buf_mem[$past(wr_ptr)][DW*3+2])
        else $error("correction flagged outside application mode");
    a_apply_needs_est: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE13
        acc && !est_valid && act_focus >= FOCUS_AUTO_BIT |=> !buf_mem[$past(wr_ptr)][DW*3+2])
        else $error("auto correction without a prior estimate");
    a_est_at_eof: assert property (@(posedge sys_clk) disable iff (!rst_b)      // RULE4
        $changed(est_dist) |-> $past(acc && in_eof && act_mode == DMS_MODE_ESTIM))
        else $error("estimate changed away from an estimation frame end");
    a_votes_estim: assert property (@(posedge sys_clk) disable iff (!rst_b)     // RULE5
        acc && act_mode == DMS_MODE_ESTIM && !in_eof && has_vote && win == 2'h0 && roi_w != 3'h0
        |=> votes[0] == $past(votes[0]) + AW'($past(roi_w)))
        else $error("blue vote not counted with its zone weight");
    a_votes_idle: assert property (@(posedge sys_clk) disable iff (!rst_b)      // RULE7
        !(acc && act_mode == DMS_MODE_ESTIM) |=> $stable(votes[1]) && $stable(votes[2]))
        else $error("votes moved outside estimation");
    a_cfg_frame_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)  // RULE16
        !(acc && in_sof) |=> $stable(cfg_mode_q) && $stable(cfg_focus_q) && $stable(cfg_roi_q))
        else $error("settings changed inside a frame");
    a_out_stall_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
        out_valid && !out_ready |=> out_valid && $stable(out_r) && $stable(out_b) && $stable(out_eof))
        else $error("stalled output word changed");
    a_full_stalls: assert property (@(posedge sys_clk) disable iff (!rst_b)
        count == BUF_FULL && !out_ready |=> !in_ready [*1] ##0 count == BUF_FULL)
        else $error("full buffer accepted a word");
endmodule
`default_nettype wire

/* File: core/dms_pkg.sv */
// Shared constants, types and helpers for the distance mode select block.
// Assumes one 100 MHz system clock and a synchronous active-low reset.
package dms_pkg;

    // -------------------------------------------------------------
    // Clock
    // -------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;          // sys_clk period

    // -------------------------------------------------------------
    // Operating modes and correction ranges
    // -------------------------------------------------------------
    typedef enum logic [1:0] {
        DMS_MODE_OFF   = 2'h0,                  // Engine idle, saves power
        DMS_MODE_APPLY = 2'h1,                  // Capture: correction applied
        DMS_MODE_ESTIM = 2'h2                   // Preview: votes gathered
    } dms_mode_e;

    typedef enum logic [1:0] {
        DMS_RANGE_SMACRO    = 2'h0,             // Below 30 cm, monochrome
        DMS_RANGE_MACRO     = 2'h1,             // 30 to 49 cm
        DMS_RANGE_PORTRAIT  = 2'h2,             // 50 to 119 cm
        DMS_RANGE_LANDSCAPE = 2'h3              // 120 cm and beyond
    } dms_range_e;

    // -------------------------------------------------------------
    // Distance boundaries and reported distances (cm)
    // -------------------------------------------------------------
    localparam logic [15:0] MACRO_MIN_CM     = 16'h001E;    // 30 cm
    localparam logic [15:0] PORTRAIT_MIN_CM  = 16'h0032;    // 50 cm
    localparam logic [15:0] LANDSCAPE_MIN_CM = 16'h0078;    // 120 cm
    localparam logic [15:0] FOCUS_AUTO_BIT   = 16'h8000;    // 0x8000 and up: auto
    localparam logic [7:0]  EST_MACRO_CM     = 8'h1E;       // Reported for macro
    localparam logic [7:0]  EST_PORTRAIT_CM  = 8'h32;       // Reported for portrait
    localparam logic [7:0]  EST_LANDSCAPE_CM = 8'h78;       // Reported for landscape
    localparam logic [7:0]  EST_DIST_RST     = 8'h20;       // Estimate after reset

    // -------------------------------------------------------------
    // Region of interest selection codes and 5x5 zone geometry
    // -------------------------------------------------------------
    localparam logic [3:0] ROI_CENTRE = 4'h2;   // Centre weighted
    localparam logic [3:0] ROI_LARGE  = 4'h4;   // Large spot
    localparam logic [3:0] ROI_NARROW = 4'h8;   // Narrow spot
    localparam logic [2:0] ZONE_MID   = 3'h2;   // Middle row/column of 5
    localparam logic [2:0] ZONE_LO    = 3'h1;   // Inner ring bounds
    localparam logic [2:0] ZONE_HI    = 3'h3;
    localparam logic [2:0] ROI_W_HIGH = 3'h4;   // Centre zone weight
    localparam logic [2:0] ROI_W_MID  = 3'h2;   // Inner ring weight
    localparam logic [2:0] ROI_W_ONE  = 3'h1;   // Plain weight
    localparam logic [2:0] ROI_W_NONE = 3'h0;   // Zone ignored

    // Buffer depth: two entries
    localparam logic [1:0] BUF_FULL = 2'h2;

    // Same boundaries for manual and estimated distances
    function automatic dms_range_e dms_classify(input logic [15:0] cm);
        if (cm < MACRO_MIN_CM)
            return DMS_RANGE_SMACRO;
        else if (cm < PORTRAIT_MIN_CM)
            return DMS_RANGE_MACRO;
        else if (cm < LANDSCAPE_MIN_CM)
            return DMS_RANGE_PORTRAIT;
        else
            return DMS_RANGE_LANDSCAPE;
    endfunction

endpackage

/* File: tb/dms_sink.sv */
// Downstream pixel receiver facing the output side of the distance mode block.
// Assumes the bench picks its pace; it never drops a word, it only stalls.
`timescale 1ns/100ps
`default_nettype none
module dms_sink (
    input  wire logic       sys_clk,
    input  wire logic       rst_b,
    input  wire logic [1:0] pace,       // 0 prompt, 1 random stalls, 2 held off
    output logic            out_ready
);
    // ---------------------------------------------
    // Ready pacing
    // ---------------------------------------------
    int seed = 32'h49d8;                // Fixed seed so runs repeat

    // Moves only at the falling edge so the block samples a settled level
    always @(negedge sys_clk) begin
        if (rst_b !== 1'b1)
            out_ready <= 1'b0;
        else if (pace == 2'h0)
            out_ready <= 1'b1;
        else if (pace == 2'h1)
            out_ready <= ($random(seed) & 3) != 0;
        else
            out_ready <= 1'b0;          // Long stall, to fill the buffer
    end
endmodule
`default_nettype wire

/* File: tb/tb_dms_core.sv */
// Self-checking bench for the distance mode select core with a stalling sink.
// Assumes default sample widths and a reference model kept in this file.
`timescale 1ns/100ps
`default_nettype none
module tb_dms_core
    import dms_pkg::*;
;
    // ---------------------------------------------
    // Signals and model state
    // ---------------------------------------------
    typedef struct packed {
        logic       sof;
        logic       eof;
        logic [9:0] r;
        logic [9:0] g;
        logic [9:0] b;
        logic [1:0] rng;
        logic       corr;
    } dms_exp_s;
    logic        sys_clk, rst_b, in_valid, in_ready, in_sof, in_eof, out_valid, out_ready;
    logic        out_sof, out_eof, out_corr, est_valid;
    logic [1:0]  cfg_mode, out_range, act_mode_rd, pace;
    logic [15:0] cfg_focus, act_focus_rd;
    logic [3:0]  cfg_roi, act_roi_rd;
    logic [9:0]  in_r, in_g, in_b, out_r, out_g, out_b;
    logic [2:0]  in_zone_x, in_zone_y;
    logic [7:0]  cal_w_r, cal_w_g, cal_w_b, est_dist;
    logic [7:0]  m_est = 8'h20;         // Model estimate after reset
    logic        m_ev = 1'b0;
    int          seed = 32'h49d8;
    int          n_fail = 0, n_compared = 0;
    int          v[3] = '{0, 0, 0};     // Macro, portrait, landscape votes
    int          pr, pg, pb;            // Previous taken pixel
    dms_exp_s    q[$];                  // Words expected at the output
    logic [15:0] foc[8] = '{16'h0000, 16'h001D, 16'h001E, 16'h0031, 16'h0032, 16'h0077, 16'h0078, 16'h7FFF};
    logic [3:0]  rois[6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'h5};

    dms_core dut (.sys_clk(sys_clk), .rst_b(rst_b), .cfg_mode(cfg_mode), .cfg_focus(cfg_focus),
        .cfg_roi(cfg_roi), .in_valid(in_valid), .in_ready(in_ready), .in_sof(in_sof), .in_eof(in_eof),
        .in_r(in_r), .in_g(in_g), .in_b(in_b), .in_zone_x(in_zone_x), .in_zone_y(in_zone_y),
        .cal_w_r(cal_w_r), .cal_w_g(cal_w_g), .cal_w_b(cal_w_b), .out_valid(out_valid),
        .out_ready(out_ready), .out_sof(out_sof), .out_eof(out_eof), .out_r(out_r), .out_g(out_g),
        .out_b(out_b), .out_range(out_range), .out_corr(out_corr), .est_dist(est_dist),
        .est_valid(est_valid), .act_mode_rd(act_mode_rd), .act_focus_rd(act_focus_rd),
        .act_roi_rd(act_roi_rd));
    dms_sink sink (.sys_clk(sys_clk), .rst_b(rst_b), .pace(pace), .out_ready(out_ready));

    // ---------------------------------------------
    // Clock, watchdog and compare helpers
    // ---------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // The whole run needs under a thousand cycles; 20k means a hang
    initial begin
        #200000;
        n_fail++;
        results();
    end
    task automatic results();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask
    // Range travels with every word, corrected or not
    task automatic chk_word(input dms_exp_s e);
        n_compared++;
        if ({out_sof, out_eof, out_r, out_g, out_b, out_corr, out_range} !==
            {e.sof, e.eof, e.r, e.g, e.b, e.corr, e.rng}) begin
            n_fail++;
            $display("BAD %0t output word differs", $time);
        end
    endtask
    function automatic logic [1:0] cls(input logic [15:0] cm);
        return (cm < MACRO_MIN_CM) ? 2'h0 : (cm < PORTRAIT_MIN_CM) ? 2'h1 : (cm < LANDSCAPE_MIN_CM) ? 2'h2 : 2'h3;
    endfunction
    function automatic int zw(input logic [3:0] roi, input int x, input int y);
        int inner;
        inner = (x >= 1 && x <= 3 && y >= 1 && y <= 3);
        if (roi == 4'h2)
            return (x == 2 && y == 2) ? 4 : inner ? 2 : 1;
        if (roi == 4'h4)
            return inner;
        if (roi == 4'h8)
            return (x == 2 && y == 2);
        return 1;                       // Uniform, also for unlisted codes
    endfunction

    // ---------------------------------------------
    // Monitor: pops the oldest note at every accepted word
    // ---------------------------------------------
    always @(posedge sys_clk) begin
        if (rst_b === 1'b1 && out_valid === 1'b1 && out_ready === 1'b1) begin
            if (q.size() == 0) begin
                n_fail++;
                $display("BAD %0t word with no note", $time);
            end else
                chk_word(q.pop_front());
        end
    end

    // ---------------------------------------------
    // Frame driver with reference model
    // ---------------------------------------------
    task automatic send_frame(input logic [1:0] md, input logic [15:0] fc, input logic [3:0] roi, input int n);
        int wd, gr, gg, gb, x, y;
        dms_exp_s e;
        for (int i = 0; i < n; i++) begin
            @(negedge sys_clk);
            if (i == 0) begin
                cfg_mode = md;
                cfg_focus = fc;
                cfg_roi = roi;
            end else begin
                cfg_mode = 2'($random(seed));
                cfg_focus = 16'($random(seed));
                cfg_roi = 4'($random(seed));
            end
            {in_valid, in_sof, in_eof} = {1'b1, i == 0, i == n - 1};
            {in_r, in_g, in_b} = 30'($random(seed));
            {cal_w_r, cal_w_g, cal_w_b} = 24'($random(seed));
            x = ($random(seed) & 32'hFFFF) % 5;
            y = ($random(seed) & 32'hFFFF) % 5;
            in_zone_x = 3'(x);
            in_zone_y = 3'(y);
            wd = 0;
            while (in_ready !== 1'b1 && wd < 200) begin
                @(negedge sys_clk);
                wd++;
            end
            @(posedge sys_clk);
            e.corr = (md == 2'h1) && (fc < FOCUS_AUTO_BIT || m_ev);
            e.rng = (fc < FOCUS_AUTO_BIT) ? cls(fc) : cls({8'h00, m_est});
            {e.sof, e.eof, e.r, e.g, e.b} = {in_sof, in_eof, in_r, in_g, in_b};
            if (e.corr && e.rng == 2'h0)
                {e.r, e.g} = {in_b, in_b};
            q.push_back(e);
            gr = (i == 0) ? 0 : ((in_r > pr) ? in_r - pr : pr - in_r) * cal_w_r;
            gg = (i == 0) ? 0 : ((in_g > pg) ? in_g - pg : pg - in_g) * cal_w_g;
            gb = (i == 0) ? 0 : ((in_b > pb) ? in_b - pb : pb - in_b) * cal_w_b;
            {pr, pg, pb} = {int'(in_r), int'(in_g), int'(in_b)};
            if (md == 2'h2) begin
                if (gb >= gg && gb >= gr && gb > 0)
                    v[0] += zw(roi, x, y);
                else if (gg >= gr && gg > 0)
                    v[1] += zw(roi, x, y);
                else if (gr > 0)
                    v[2] += zw(roi, x, y);
                if (i == n - 1) begin
                    m_est = (v[0] >= v[1] && v[0] >= v[2]) ? EST_MACRO_CM : (v[1] >= v[2]) ? EST_PORTRAIT_CM : EST_LANDSCAPE_CM;
                    m_ev = 1'b1;
                    v = '{0, 0, 0};
                end
            end
        end
        @(negedge sys_clk);
        {in_valid, in_sof, in_eof} = 3'h0;
        wd = 0;
        while (q.size() != 0 && wd < 1000) begin
            @(negedge sys_clk);
            wd++;
        end
        chk_val(16'(wd), 16'(wd % 1000), "drain");
        chk_val(16'(est_dist), 16'(m_est), "estimate");
        chk_val(16'(est_valid), 16'(m_ev), "estimate valid");
        chk_val(16'({act_mode_rd, act_roi_rd}), 16'({md, roi}), "latched mode");
        chk_val(act_focus_rd, fc, "latched focus");
    endtask

    // ---------------------------------------------
    // Main sequence
    // ---------------------------------------------
    initial begin
        {rst_b, in_valid, in_sof, in_eof, pace} = 5'h0;
        {cfg_mode, cfg_focus, cfg_roi, in_r, in_g, in_b} = '0;
        {in_zone_x, in_zone_y, cal_w_r, cal_w_g, cal_w_b} = '0;
        repeat (12) @(negedge sys_clk);
        rst_b = 1'b1;
        chk_val(16'({in_ready, out_valid, est_valid, act_mode_rd, act_roi_rd}), 16'h0100, "reset flags");
        chk_val({est_dist, 8'h00}, {EST_DIST_RST, 8'h00}, "reset estimate");
        chk_val(act_focus_rd, 16'h8000, "reset focus");
        send_frame(2'h1, 16'h8000, 4'h0, 8);
        pace = 2'h1;
        foreach (foc[k])
            send_frame(2'h1, foc[k], 4'h0, 6);
        // Held-off sink: two words fill the buffer and input must stall
        pace = 2'h2;
        fork
            send_frame(2'h2, 16'hFFFF, 4'h0, 6);
            begin
                repeat (5) @(negedge sys_clk);
                chk_val(16'({in_ready, out_valid}), 16'h0001, "buffer full");
                pace <= 2'h1;
            end
        join
        foreach (rois[k])
            send_frame(2'h2, 16'h8000, rois[k], 40);
        send_frame(2'h0, 16'h8000, 4'h2, 10);
        send_frame(2'h3, 16'hFFFF, 4'h2, 10);
        send_frame(2'h1, 16'hC000, 4'h2, 10);
        results();
    end
endmodule
`default_nettype wire
